// ---- btqp_pkg.sv ----
// constants and types shared by the speed one-shot and the gate logic
package btqp_pkg;

    localparam int CNT_W  = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // clock and default speed-pulse on-time
    localparam int CLK_PERIOD_NS   = 50;
    localparam int TON_DEFAULT_US  = 100;
    localparam int TON_DEFAULT_CYC = (TON_DEFAULT_US * 1000) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] TON_RESET = TON_DEFAULT_CYC[CNT_W-1:0];

    // register map, word addresses on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_TON   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_EDGES = 4'h2;

    // status register fields
    localparam int STAT_HALL_LSB  = 0;
    localparam int STAT_PULSE_BIT = 3;
    localparam int STAT_BAD_BIT   = 4;
    localparam int STAT_DIR_BIT   = 5;
    localparam int STAT_QUAD_BIT  = 6;
    localparam int STAT_GATE_LSB  = 7;
    localparam int STAT_USED_W    = 13;

    // hall codes, bit 2 = phase a, bit 0 = phase c
    localparam logic [2:0] HALL_ALL_LOW  = 3'h0;
    localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

    // one-hot phase selects
    localparam logic [2:0] PH_A    = 3'h4;
    localparam logic [2:0] PH_B    = 3'h2;
    localparam logic [2:0] PH_C    = 3'h1;
    localparam logic [2:0] PH_NONE = 3'h0;

    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } btqp_gate_t;

    localparam btqp_gate_t GATE_OFF = '{hi: PH_NONE, lo: PH_NONE};

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } btqp_bus_t;

endpackage

// ---- btqp_oneshot.sv ----
// retriggerable speed-pulse monostable
module btqp_oneshot
    import btqp_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             trig,
    input  wire logic [CNT_W-1:0] width,
    output logic                  pulse
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             pulse_r;

    // a fresh edge reloads the full width, even mid-pulse
    assign cnt_nxt = trig ? width
                   : (cnt_r != '0) ? cnt_r - {{(CNT_W-1){1'b0}}, 1'b1}
                   : '0;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_r   <= '0;
            pulse_r <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            pulse_r <= (cnt_nxt != '0);
        end
    end

    assign pulse = pulse_r;

    property p_width_load;
        @(posedge mclk) disable iff (rst)
        (trig && width != '0) |=> (cnt_r == $past(width)) && pulse_r;
    endproperty
    a_width_load: assert property (p_width_load)
        else $error("one-shot did not load the on-time");

    property p_pulse_end;
        @(posedge mclk) disable iff (rst)
        $fell(pulse_r) |->
            (($past(cnt_r) == 1) && !$past(trig)) ||
            ($past(trig) && ($past(width) == '0));
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("speed pulse ended before its count ran out");

    property p_retrigger;
        @(posedge mclk) disable iff (rst)
        (trig && pulse_r && width != '0) |=>
            pulse_r && (cnt_r == $past(width));
    endproperty
    a_retrigger: assert property (p_retrigger)
        else $error("retrigger did not restart the on-time");

endmodule

// ---- btqp_top.sv ----
// hall decode, speed pulse and quadrant PWM chopping of the gate commands
// Notes on behaviour
// - Any hall input edge, rising or falling, fires the speed one-shot.
// - One pulse per hall edge: six per electrical turn, rpm*pairs/10 Hz.
// - Pulse stays high for the programmed on-time count.
// - Quadrant select low: only low-side commands are chopped.
// - Two-quadrant: on interval both on; off interval low side off only.
// - Quadrant select high: high and low side both chopped together.
// - Direction change swaps to the opposite diagonal pair, same phases.
// - After reversal in two-quadrant, off interval drops only new low side.
// - A hall edge during the pulse restarts the on-time from zero.
//
// The register addresses and strobed register access were decided locally.
module btqp_top
    import btqp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              hall_phase_a,
    input  wire logic              hall_phase_b,
    input  wire logic              hall_phase_c,
    input  wire logic              dirIn,
    input  wire logic              quadSel,
    input  wire logic              pwmOn,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    output btqp_gate_t             gateCmd,
    output logic                   speed_pulse_out
);

    // two-flop synchronisers for the hall, direction, quadrant and PWM pin inputs
    logic [5:0] pinMeta_r;
    logic [5:0] pinSync_r;
    logic [2:0] hallPrev_r;

    logic [2:0] hallSync;
    logic       dirSync;
    logic       quadSync;
    logic       pwmSync;
    logic       hallEdge;
    logic       hallValid;
    logic [2:0] settle_r;
    logic       armed;

    btqp_bus_t        bus;
    logic [CNT_W-1:0] tonCount_r;
    logic [CNT_W-1:0] edgeCount_r;
    logic [DATA_W-1:0] regRdata_r;
    logic [DATA_W-1:0] statWord;
    logic [DATA_W-1:0] readMux;

    btqp_gate_t baseGate;
    btqp_gate_t gateNxt;
    btqp_gate_t gate_r;
    logic       speedPulse;

    // hall code to gate pair; reverse direction swaps the pair's sides
    function automatic btqp_gate_t commute(input logic [2:0] code,
                                           input logic       dirFwd);
        btqp_gate_t g;
        g = GATE_OFF;
        case (code)
            3'h5:    g = '{hi: PH_A, lo: PH_B};
            3'h4:    g = '{hi: PH_A, lo: PH_C};
            3'h6:    g = '{hi: PH_B, lo: PH_C};
            3'h2:    g = '{hi: PH_B, lo: PH_A};
            3'h3:    g = '{hi: PH_C, lo: PH_A};
            3'h1:    g = '{hi: PH_C, lo: PH_B};
            default: g = GATE_OFF;
        endcase
        if (!dirFwd)
        begin
            g = '{hi: g.lo, lo: g.hi};
        end
        return g;
    endfunction

    assign bus = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pinMeta_r  <= 6'h00;
            pinSync_r  <= 6'h00;
            hallPrev_r <= 3'h0;
        end
        else
        begin
            pinMeta_r  <= {hall_phase_a, hall_phase_b, hall_phase_c,
                           dirIn, quadSel, pwmOn};
            pinSync_r  <= pinMeta_r;
            hallPrev_r <= hallSync;
        end
    end

    // edges held off until the synchroniser holds real pin levels,
    // else the reset value of the previous code reads as a change
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            settle_r <= 3'h0;
        end
        else
        begin
            settle_r <= {settle_r[1:0], 1'b1};
        end
    end

    assign armed    = settle_r[2];
    assign hallSync = pinSync_r[5:3];
    assign dirSync  = pinSync_r[2];
    assign quadSync = pinSync_r[1];
    assign pwmSync  = pinSync_r[0];

    assign hallEdge  = armed && (hallSync != hallPrev_r);
    assign hallValid = (hallSync != HALL_ALL_LOW) &&
                       (hallSync != HALL_ALL_HIGH);

    // one pulse per edge gives the six-per-revolution frequency
    btqp_oneshot btqp_oneshot_inst
    (
        .mclk  (mclk),
        .rst   (rst),
        .trig  (hallEdge),
        .width (tonCount_r),
        .pulse (speedPulse)
    );

    assign baseGate = commute(hallSync, dirSync);

    // two-quadrant leaves the high side on through the off interval
    assign gateNxt.lo = pwmSync ? baseGate.lo : PH_NONE;
    assign gateNxt.hi = (!quadSync || pwmSync) ? baseGate.hi
                      : PH_NONE;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            gate_r <= GATE_OFF;
        end
        else
        begin
            gate_r <= gateNxt;
        end
    end

    // register port; on-time is not checked against speed, software's job
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tonCount_r  <= TON_RESET;
            edgeCount_r <= '0;
            regRdata_r  <= '0;
        end
        else
        begin
            if (bus.wr && bus.addr == ADDR_TON)
            begin
                tonCount_r <= bus.wdata;
            end
            if (hallEdge)
            begin
                edgeCount_r <= edgeCount_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            regRdata_r <= bus.rd ? readMux : '0;
        end
    end

    assign statWord = {{(DATA_W-STAT_USED_W){1'b0}},
                       gate_r, quadSync, dirSync, !hallValid,
                       speedPulse, hallSync};

    assign readMux = (bus.addr == ADDR_TON)   ? tonCount_r  :
                     (bus.addr == ADDR_STAT)  ? statWord    :
                     (bus.addr == ADDR_EDGES) ? edgeCount_r :
                     '0;

    assign regRdata        = regRdata_r;
    assign gateCmd         = gate_r;
    assign speed_pulse_out = speedPulse;

    property p_edge_fires;
        @(posedge mclk) disable iff (rst)
        (hallEdge && tonCount_r != '0) |=> speedPulse;
    endproperty
    a_edge_fires: assert property (p_edge_fires)
        else $error("hall edge did not raise the speed pulse");

    property p_edge_count;
        @(posedge mclk) disable iff (rst)
        hallEdge |=> edgeCount_r == $past(edgeCount_r) + 16'h0001;
    endproperty
    a_edge_count: assert property (p_edge_count)
        else $error("hall edge was not counted once");

    property p_two_quad_high;
        @(posedge mclk) disable iff (rst)
        !quadSync |=> gate_r.hi == $past(baseGate.hi);
    endproperty
    a_two_quad_high: assert property (p_two_quad_high)
        else $error("high side chopped in two-quadrant mode");

    property p_two_quad_off;
        @(posedge mclk) disable iff (rst)
        (!quadSync && !pwmSync) ##0 (baseGate != GATE_OFF) |=>
            (gate_r.lo == PH_NONE) && (gate_r.hi != PH_NONE);
    endproperty
    a_two_quad_off: assert property (p_two_quad_off)
        else $error("two-quadrant off interval wrong");

    property p_on_interval;
        @(posedge mclk) disable iff (rst)
        pwmSync |=> gate_r == $past(baseGate);
    endproperty
    a_on_interval: assert property (p_on_interval)
        else $error("on interval does not drive the decoded pair");

    property p_four_quad_off;
        @(posedge mclk) disable iff (rst)
        (quadSync && !pwmSync) |=> gate_r == GATE_OFF;
    endproperty
    a_four_quad_off: assert property (p_four_quad_off)
        else $error("four-quadrant off interval left a switch on");

    property p_reverse_pair;
        @(posedge mclk) disable iff (rst)
        (dirSync != $past(dirSync)) && (hallSync == $past(hallSync)) |->
            (baseGate.hi == $past(baseGate.lo)) &&
            (baseGate.lo == $past(baseGate.hi));
    endproperty
    a_reverse_pair: assert property (p_reverse_pair)
        else $error("reversal did not swap to the diagonal pair");

    property p_reverse_chop;
        @(posedge mclk) disable iff (rst)
        (dirSync != $past(dirSync)) ##0 (!quadSync && !pwmSync) |=>
            (gate_r.lo == PH_NONE) && (gate_r.hi == $past(baseGate.hi));
    endproperty
    a_reverse_chop: assert property (p_reverse_chop)
        else $error("after reversal the high side was chopped");

    property p_decode_shape;
        @(posedge mclk) disable iff (rst)
        hallValid |-> $onehot(baseGate.hi) && $onehot(baseGate.lo) &&
            ((baseGate.hi & baseGate.lo) == PH_NONE);
    endproperty
    a_decode_shape: assert property (p_decode_shape)
        else $error("valid hall code gave a bad phase pair");

    property p_invalid_off;
        @(posedge mclk) disable iff (rst)
        !hallValid |=> gate_r == GATE_OFF;
    endproperty
    a_invalid_off: assert property (p_invalid_off)
        else $error("invalid hall code left a switch on");

    property p_rise_needs_edge;
        @(posedge mclk) disable iff (rst)
        $rose(speedPulse) |-> $past(hallEdge);
    endproperty
    a_rise_needs_edge: assert property (p_rise_needs_edge)
        else $error("speed pulse rose without a hall edge");

    property p_quiet_after_reset;
        @(posedge mclk) disable iff (rst)
        !armed |=> !speedPulse;
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset)
        else $error("speed pulse fired before the inputs settled");

    property p_retrig_top;
        @(posedge mclk) disable iff (rst)
        (hallEdge && speedPulse && tonCount_r != '0) |=> speedPulse;
    endproperty
    a_retrig_top: assert property (p_retrig_top)
        else $error("edge during the pulse let it drop");

    property p_ton_write;
        @(posedge mclk) disable iff (rst)
        (bus.wr && bus.addr == ADDR_TON) |=> tonCount_r == $past(bus.wdata);
    endproperty
    a_ton_write: assert property (p_ton_write)
        else $error("on-time write did not land");

    property p_low_chopped;
        @(posedge mclk) disable iff (rst)
        !pwmSync |=> gate_r.lo == PH_NONE;
    endproperty
    a_low_chopped: assert property (p_low_chopped)
        else $error("low side stayed on in the off interval");

    property p_no_shoot;
        @(posedge mclk) disable iff (rst)
        (gate_r.hi & gate_r.lo) == PH_NONE;
    endproperty
    a_no_shoot: assert property (p_no_shoot)
        else $error("one leg has both switches on");

endmodule

// ---- btqp_motor_model.sv ----
// hall sensor and inverter stand-in facing the gate logic
module btqp_motor_model
    import btqp_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       step,
    input  wire logic [1:0] badCode,
    input  wire btqp_gate_t gateCmd,
    output logic            hall_phase_a,
    output logic            hall_phase_b,
    output logic            hall_phase_c,
    output logic            shorted
);
    timeunit 1ns;
    timeprecision 1ns;

    // forward rotation order, never all high or all low
    localparam logic [2:0] SEQ [6] =
        '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

    logic [2:0] pos_r;
    logic [2:0] code;

    always_ff @(posedge mclk)
    begin
        if (rst)
            pos_r <= 3'h0;
        else if (step)
            pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
    end

    // broken sensor only when a test asks for it
    assign code = badCode[1] ? {3{badCode[0]}} : SEQ[pos_r];
    assign {hall_phase_a, hall_phase_b, hall_phase_c} = code;
    // one leg with both switches on would short the supply
    assign shorted = |(gateCmd.hi & gateCmd.lo);
endmodule

// ---- btqp_top_test.sv ----
// self-checking bench: registers, speed pulse and gate chopping
module btqp_top_test
    import btqp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              mclk;
    logic              rst;
    logic              dirIn;
    logic              quadSel;
    logic              pwmOn;
    logic              regWr;
    logic              regRd;
    logic              step;
    logic              shorted;
    logic              speed_pulse_out;
    logic              hall_phase_a;
    logic              hall_phase_b;
    logic              hall_phase_c;
    logic [1:0]        badCode;
    logic [2:0]        hallNow;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic [DATA_W-1:0] regRdata;
    btqp_gate_t        gateCmd;
    int                badCount;
    int                nChecks;
    int                len;

    btqp_top btqp_top_inst (
        .mclk(mclk), .rst(rst), .hall_phase_a(hall_phase_a),
        .hall_phase_b(hall_phase_b), .hall_phase_c(hall_phase_c),
        .dirIn(dirIn), .quadSel(quadSel), .pwmOn(pwmOn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .gateCmd(gateCmd),
        .speed_pulse_out(speed_pulse_out)
    );

    btqp_motor_model btqp_motor_model_inst (
        .mclk(mclk), .rst(rst), .step(step), .badCode(badCode),
        .gateCmd(gateCmd), .hall_phase_a(hall_phase_a),
        .hall_phase_b(hall_phase_b), .hall_phase_c(hall_phase_c),
        .shorted(shorted)
    );

    assign hallNow = {hall_phase_a, hall_phase_b, hall_phase_c};

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task rdc(input string nm, input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        chk(nm, regRdata, exp);
        @(negedge mclk);
        chk("rdata idle", regRdata, 16'h0000);
    endtask

    task do_step;
        @(posedge mclk);
        step <= 1'b1;
        @(posedge mclk);
        step <= 1'b0;
    endtask

    // bounded wait for the rise, then count high cycles
    task pulse_len(output int n);
        n = 0;
        repeat (20) if (speed_pulse_out !== 1'b1) @(negedge mclk);
        while (speed_pulse_out === 1'b1 && n < 300)
        begin
            n++;
            @(negedge mclk);
        end
    endtask

    // kept apart from the design's table on purpose
    function automatic btqp_gate_t expGate(logic [2:0] h, logic d,
                                           logic q, logic p);
        btqp_gate_t g;
        case (h)
            3'h5: g = '{hi: PH_A, lo: PH_B};
            3'h4: g = '{hi: PH_A, lo: PH_C};
            3'h6: g = '{hi: PH_B, lo: PH_C};
            3'h2: g = '{hi: PH_B, lo: PH_A};
            3'h3: g = '{hi: PH_C, lo: PH_A};
            3'h1: g = '{hi: PH_C, lo: PH_B};
            default: g = GATE_OFF;
        endcase
        if (!d) g = '{hi: g.lo, lo: g.hi};
        if (!p) g.lo = PH_NONE;
        if (!p && q) g.hi = PH_NONE;
        return g;
    endfunction

    task test_done;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        badCount++;
        test_done;
    end

    initial
    begin
        {rst, dirIn, quadSel, pwmOn, regWr, regRd, step} = 7'h40;
        badCode = 2'h0;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk("gate in reset", 16'(gateCmd), 16'h0000);
        chk("pulse in reset", 16'(speed_pulse_out), 16'h0000);
        @(posedge mclk);
        rst <= 1'b0;
        repeat (5) @(posedge mclk);
        rdc("ton reset", ADDR_TON, TON_RESET);
        rdc("edges reset", ADDR_EDGES, 16'h0000);
        // on-time below the commutation-test hall spacing, above the 5-cycle spacing of the retrigger step pair
        wr(ADDR_TON, 16'h0008);
        wr(ADDR_STAT, 16'hFFFF);
        wr(ADDR_EDGES, 16'h00FF);
        wr(4'hF, 16'h1234);
        rdc("ton", ADDR_TON, 16'h0008);
        rdc("edges ro", ADDR_EDGES, 16'h0000);
        rdc("unmapped", 4'hF, 16'h0000);
        $display("test registers done");
        repeat (2100) @(posedge mclk);
        do_step;
        pulse_len(len);
        chk("pulse width", 16'(len), 16'h0008);
        fork
            pulse_len(len);
            begin
                do_step;
                repeat (3) @(posedge mclk);
                do_step;
            end
        join
        chk("retrigger width", 16'(len), 16'h000D);
        $display("test speed pulse done");
        for (int p = 0; p < 6; p++)
        begin
            for (int m = 0; m < 8; m++)
            begin
                @(posedge mclk);
                {dirIn, quadSel, pwmOn} <= m[2:0];
                repeat (5) @(posedge mclk);
                @(negedge mclk);
                chk("gate", 16'(gateCmd),
                    16'(expGate(hallNow, dirIn, quadSel, pwmOn)));
                chk("shoot", 16'(shorted), 16'h0000);
            end
            do_step;
        end
        $display("test commutation done");
        for (int b = 2; b < 4; b++)
        begin
            @(posedge mclk);
            badCode <= b[1:0];
            {dirIn, quadSel, pwmOn} <= 3'h5;
            repeat (5) @(posedge mclk);
            @(negedge mclk);
            chk("gate bad code", 16'(gateCmd), 16'h0000);
        end
        repeat (20) @(posedge mclk);
        rdc("status", ADDR_STAT, 16'h0037);
        rdc("edges", ADDR_EDGES, 16'h000B);
        $display("test invalid codes done");
        test_done;
    end
endmodule
